// ### shared/pss_pkg.sv
// Shared constants and types for the secondary split status register block
package pss_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0]  PSS_OFF_CAP   = 8'h80; // Capability dword
  localparam logic [7:0]  PSS_OFF_ISTAT = 8'hA0; // Interrupt status
  localparam logic [7:0]  PSS_OFF_IMASK = 8'hA4; // Interrupt mask

  // ---------------------------------------------------------------
  // Field positions inside the capability dword
  // ---------------------------------------------------------------
  localparam int          PSS_B_PTR     = 8;     // Next pointer byte low
  localparam int          PSS_B_64      = 16;    // 64-bit capable
  localparam int          PSS_B_133     = 17;    // 133MHz capable
  localparam int          PSS_B_FLAG    = 18;    // First sticky flag
  localparam int          PSS_B_FREQ    = 22;    // Clock frequency low
  localparam int          PSS_NFLAG     = 4;     // Sticky flag count
  localparam int          PSS_FREQ_W    = 3;     // Frequency field width

  // ---------------------------------------------------------------
  // Reset and fixed values
  // ---------------------------------------------------------------
  localparam logic [7:0]  PSS_NEXT_CAP  = 8'h90; // Links to power mgmt
  localparam logic [3:0]  PSS_MASK_RST  = 4'h0;  // All events masked
  localparam logic [31:0] PSS_WORD_ZERO = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Secondary clock frequency codes
  // ---------------------------------------------------------------
  localparam logic [2:0]  PSS_FREQ_CONV = 3'h0;  // Conventional PCI
  localparam logic [2:0]  PSS_FREQ_66   = 3'h1;  // 66MHz, 15ns minimum
  localparam logic [2:0]  PSS_FREQ_133  = 3'h2;  // 100-133MHz, 7.5ns

  // ---------------------------------------------------------------
  // Bus encodings
  // ---------------------------------------------------------------
  localparam logic [1:0]  PSS_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0]  PSS_HSIZE_WORD    = 3'h2;
  localparam logic        PSS_HRESP_OKAY    = 1'b0;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  // Event strobes, bit order matches flag order in the dword
  typedef struct packed
  {
    logic delay;  // Split request held back by commitment limit
    logic ovrn;   // Completion cut short by full buffer
    logic unexp;  // Unexpected completion to our own ID
    logic disc;   // Completion dropped, requester never took it
  } pss_evt_t;

  // Bus slave sequencing
  typedef enum logic [1:0]
  {
    ST_IDLE,
    ST_WR,
    ST_RD1,
    ST_RD2
  } pss_state_t;

endpackage : pss_pkg

// ### hdl/pss_flag.sv
// One sticky write-one-to-clear flag with a mode enable
`timescale 1ns/10ps

module pss_flag
  import pss_pkg::*;
(
  input  wire logic clk_in,    // Core clock
  input  wire logic rst_n_in,  // Synchronous reset, active low
  input  wire logic en_in,     // Flag exists in this mode
  input  wire logic set_in,    // Hardware event
  input  wire logic clr_in,    // Software write of one
  output logic      flag_out   // Current flag value
);

  // ---------------------------------------------------------------
  // Flag storage
  // ---------------------------------------------------------------
  // A disabled flag is held at zero so it reads zero in that mode.
  // Set beats clear so an event landing on the clear cycle survives.
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || !en_in)
    begin
      flag_out <= 1'b0;
    end
    else if (set_in)
    begin
      flag_out <= 1'b1;
    end
    else if (clr_in)
    begin
      flag_out <= 1'b0;
    end
  end

endmodule : pss_flag

// ### hdl/pss_regs.sv
// Secondary split status register block with AHB-Lite slave
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/10ps

// Operation
// - Next pointer byte reads fixed 0x90
// - Secondary 64-bit bit always reads zero
// - 133MHz bit is one forward, zero reverse
// - Discarded completion sets the discard flag
// - Discard flag reads zero in reverse mode
// - Unexpected own-ID completion sets unexpected flag
// - Unexpected flag reads zero in forward mode
// - Full buffer cutting completion sets overrun flag
// - Commitment limit stall sets request-delayed flag
// - Frequency field codes conventional, 66, 133
// - Frequency field forced zero in reverse mode

module pss_regs
  import pss_pkg::*;
#(
  parameter int ADDR_W = 8   // Decoded address bits
)
(
  input  wire logic        clk_in,       // Core clock, 200 MHz
  input  wire logic        rst_n_in,     // Synchronous reset, low
  // Bridge configuration and events
  input  wire logic        fwd_mode_in,  // High selects forward mode
  input  wire logic [2:0]  sec_freq_in,  // Secondary clock class
  input  wire pss_evt_t    events_in,    // One-cycle event strobes
  // AHB-Lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic [31:0]      hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // Interrupt
  output logic             irq_out       // High while unmasked event
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  pss_state_t             state_reg;     // Bus slave sequencer
  logic [ADDR_W-1:0]      addr_reg;      // Captured address phase
  logic                   word_reg;      // Access was whole word
  logic                   fwd_mode_reg;  // Captured bridge mode
  logic [PSS_FREQ_W-1:0]  freq_reg;      // Sampled clock class
  logic [PSS_NFLAG-1:0]   mask_reg;      // Interrupt enables
  logic [PSS_NFLAG-1:0]   flag_q;        // Sticky status flags
  logic [PSS_NFLAG-1:0]   irq_q;         // Sticky interrupt status
  logic [PSS_NFLAG-1:0]   flag_en;       // Flags present in mode
  logic [PSS_NFLAG-1:0]   evt_vec;       // Events as a vector
  logic [PSS_NFLAG-1:0]   clr_flag;      // Clear strobes, status
  logic [PSS_NFLAG-1:0]   clr_irq;       // Clear strobes, irq
  logic                   take;          // Address phase accepted
  logic                   wr_commit;     // Write data phase now
  logic [31:0]            rd_word;       // Read data to register

  // ---------------------------------------------------------------
  // Bridge mode capture
  // ---------------------------------------------------------------
  // Mode is a strap: followed while reset is low, then frozen
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      fwd_mode_reg <= fwd_mode_in;
    end
  end

  // ---------------------------------------------------------------
  // Secondary clock class sample
  // ---------------------------------------------------------------
  // Input is already synchronous; one flop keeps reads stable
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      freq_reg <= PSS_FREQ_CONV;
    end
    else
    begin
      freq_reg <= sec_freq_in;
    end
  end

  // ---------------------------------------------------------------
  // Bus address phase decode
  // ---------------------------------------------------------------
  // Only NONSEQ is acted on; IDLE and BUSY simply pass
  assign take      = hsel_in && hready_in &&
                     (htrans_in == PSS_HTRANS_NONSEQ);
  assign wr_commit = (state_reg == ST_WR);

  // ---------------------------------------------------------------
  // Bus sequencer
  // ---------------------------------------------------------------
  // Reads get one wait state so that a read right behind a write
  // sees the written value instead of stale state.
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      state_reg <= ST_IDLE;
    end
    else
    begin
      unique case (state_reg)
        ST_RD1:
        begin
          state_reg <= ST_RD2;
        end
        ST_IDLE, ST_WR, ST_RD2:
        begin
          // New transfer may overlap the previous data phase
          if (!take)
          begin
            state_reg <= ST_IDLE;
          end
          else if (hwrite_in)
          begin
            state_reg <= ST_WR;
          end
          else
          begin
            state_reg <= ST_RD1;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Address phase capture
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      addr_reg <= '0;
      word_reg <= 1'b0;
    end
    else if (take && (state_reg != ST_RD1))
    begin
      addr_reg <= haddr_in[ADDR_W-1:0];
      word_reg <= (hsize_in == PSS_HSIZE_WORD);
    end
  end

  // ---------------------------------------------------------------
  // Ready and response outputs
  // ---------------------------------------------------------------
  // Ready drops for exactly the first data cycle of a read
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      hreadyout_out <= 1'b1;
    end
    else if ((state_reg != ST_RD1) && take && !hwrite_in)
    begin
      hreadyout_out <= 1'b0;
    end
    else
    begin
      hreadyout_out <= 1'b1;
    end
  end

  // Every transfer, mapped or not, finishes OKAY
  always_ff @(posedge clk_in)
  begin
    hresp_out <= PSS_HRESP_OKAY;
  end

  // ---------------------------------------------------------------
  // Read data multiplexer
  // ---------------------------------------------------------------
  // Unmapped words and the capability ID byte read as zero
  always_comb
  begin
    rd_word = PSS_WORD_ZERO;
    case (addr_reg)
      PSS_OFF_CAP:
      begin
        rd_word[PSS_B_PTR +: 8]         = PSS_NEXT_CAP;
        rd_word[PSS_B_64]               = 1'b0;
        rd_word[PSS_B_133]              = fwd_mode_reg;
        rd_word[PSS_B_FLAG +: PSS_NFLAG] = flag_q;
        // Class valid only forward; reverse forces zero
        if (fwd_mode_reg)
        begin
          rd_word[PSS_B_FREQ +: PSS_FREQ_W] = freq_reg;
        end
        else
        begin
          rd_word[PSS_B_FREQ +: PSS_FREQ_W] = PSS_FREQ_CONV;
        end
      end
      PSS_OFF_ISTAT:
      begin
        rd_word[PSS_NFLAG-1:0] = irq_q;
      end
      PSS_OFF_IMASK:
      begin
        rd_word[PSS_NFLAG-1:0] = mask_reg;
      end
      default:
      begin
        rd_word = PSS_WORD_ZERO;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Read data register
  // ---------------------------------------------------------------
  // Loaded in the wait cycle, so it holds while ready is high
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      hrdata_out <= PSS_WORD_ZERO;
    end
    else if (state_reg == ST_RD1)
    begin
      hrdata_out <= rd_word;
    end
  end

  // ---------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------
  // Sub-word writes are ignored rather than merged; the bus only
  // ever issues whole words here.
  always_comb
  begin
    clr_flag = '0;
    clr_irq  = '0;
    if (wr_commit && word_reg)
    begin
      if (addr_reg == PSS_OFF_CAP)
      begin
        clr_flag = hwdata_in[PSS_B_FLAG +: PSS_NFLAG];
      end
      if (addr_reg == PSS_OFF_ISTAT)
      begin
        clr_irq = hwdata_in[PSS_NFLAG-1:0];
      end
    end
  end

  // Mask register, plain read-write
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      mask_reg <= PSS_MASK_RST;
    end
    else if (wr_commit && word_reg && (addr_reg == PSS_OFF_IMASK))
    begin
      mask_reg <= hwdata_in[PSS_NFLAG-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Flag presence per mode
  // ---------------------------------------------------------------
  always_comb
  begin
    evt_vec    = events_in;
    flag_en    = '1;
    flag_en[0] = fwd_mode_reg;
    flag_en[1] = !fwd_mode_reg;
  end

  // ---------------------------------------------------------------
  // Sticky flags and interrupt status
  // ---------------------------------------------------------------
  // Events: discard, unexpected, overrun, delayed
  for (genvar i = 0; i < PSS_NFLAG; i++)
  begin : g_flag
    // Status flag seen in the capability dword
    pss_flag u_stat
    (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .en_in    (flag_en[i]),
      .set_in   (evt_vec[i]),
      .clr_in   (clr_flag[i]),
      .flag_out (flag_q[i])
    );
    // Interrupt copy, cleared separately so software can ack
    // the line without losing the status history
    pss_flag u_irq
    (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .en_in    (1'b1),
      .set_in   (evt_vec[i] && flag_en[i]),
      .clr_in   (clr_irq[i]),
      .flag_out (irq_q[i])
    );
  end

  // ---------------------------------------------------------------
  // Interrupt output
  // ---------------------------------------------------------------
  // Registered, so the line follows status by one cycle
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      irq_out <= 1'b0;
    end
    else
    begin
      irq_out <= |(irq_q & mask_reg);
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  logic rd_cap;  // Capability dword read in its wait cycle
  assign rd_cap = (state_reg == ST_RD1) && (addr_reg == PSS_OFF_CAP);

  property p_next_cap;
    @(posedge clk_in) disable iff (!rst_n_in)
    rd_cap |=> (hrdata_out[15:8] == PSS_NEXT_CAP) && hreadyout_out;
  endproperty
  a_next_cap: assert property (p_next_cap)
    else $error("next pointer byte not 0x90");

  property p_no64;
    @(posedge clk_in) disable iff (!rst_n_in)
    rd_cap ##1 1'b1 |-> !hrdata_out[16];
  endproperty
  a_no64: assert property (p_no64)
    else $error("64-bit bit read as one");

  property p_cap133;
    @(posedge clk_in) disable iff (!rst_n_in)
    rd_cap |=> hrdata_out[17] == fwd_mode_reg;
  endproperty
  a_cap133: assert property (p_cap133)
    else $error("133MHz bit does not follow mode");

  property p_disc_set;
    @(posedge clk_in) disable iff (!rst_n_in)
    events_in.disc && fwd_mode_reg |=> flag_q[0] [*2];
  endproperty
  a_disc_set: assert property (p_disc_set)
    else $error("discard event not latched");

  property p_disc_rev;
    @(posedge clk_in) disable iff (!rst_n_in)
    !fwd_mode_reg && $past(!fwd_mode_reg) |-> !flag_q[0];
  endproperty
  a_disc_rev: assert property (p_disc_rev)
    else $error("discard flag set in reverse mode");

  property p_unexp_set;
    @(posedge clk_in) disable iff (!rst_n_in)
    events_in.unexp && !fwd_mode_reg |=> flag_q[1] && irq_q[1];
  endproperty
  a_unexp_set: assert property (p_unexp_set)
    else $error("unexpected completion not latched");

  property p_unexp_fwd;
    @(posedge clk_in) disable iff (!rst_n_in)
    fwd_mode_reg && $past(fwd_mode_reg) |-> !flag_q[1];
  endproperty
  a_unexp_fwd: assert property (p_unexp_fwd)
    else $error("unexpected flag set in forward mode");

  property p_ovrn;
    @(posedge clk_in) disable iff (!rst_n_in)
    events_in.ovrn |=> flag_q[2];
  endproperty
  a_ovrn: assert property (p_ovrn)
    else $error("overrun event not latched");

  property p_delay;
    @(posedge clk_in) disable iff (!rst_n_in)
    events_in.delay |=> flag_q[3] && irq_q[3];
  endproperty
  a_delay: assert property (p_delay)
    else $error("delayed request not latched");

  property p_freq;
    @(posedge clk_in) disable iff (!rst_n_in)
    rd_cap && fwd_mode_reg |=> hrdata_out[24:22] == $past(freq_reg);
  endproperty
  a_freq: assert property (p_freq)
    else $error("frequency field differs from input");

  property p_freq_rev;
    @(posedge clk_in) disable iff (!rst_n_in)
    rd_cap && !fwd_mode_reg |=> hrdata_out[24:22] == 3'h0;
  endproperty
  a_freq_rev: assert property (p_freq_rev)
    else $error("frequency field nonzero in reverse");

  property p_w1c;
    @(posedge clk_in) disable iff (!rst_n_in)
    clr_flag[2] && !events_in.ovrn |=>
      !flag_q[2] ##1 hrdata_out[31:25] == 7'h0;
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("write one did not clear overrun");

  property p_mode;
    @(posedge clk_in) disable iff (!rst_n_in)
    $past(rst_n_in) |-> $stable(fwd_mode_reg);
  endproperty
  a_mode: assert property (p_mode)
    else $error("bridge mode changed after reset");

endmodule : pss_regs

// ### testbench/pss_regs_bench.sv
// Self-checking bench for the secondary split status register block
`timescale 1ns/10ps

module pss_regs_bench
  import pss_pkg::*;
;
  // ------------------------------------------------------------
  // Design connections
  // ------------------------------------------------------------
  logic        clk_in = 1'b0;   // Core clock
  logic        rst_n_in;        // Synchronous reset, low
  logic        fwd_mode_in;     // Bridge mode strap
  logic [2:0]  sec_freq_in;     // Secondary clock class
  pss_evt_t    events_in;       // Event strobes
  logic        hsel_in;
  logic [31:0] haddr_in;
  logic [1:0]  htrans_in;
  logic        hwrite_in;
  logic [2:0]  hsize_in;
  logic [31:0] hwdata_in;
  wire logic   hready_in;       // Single slave, ready loops back
  logic [31:0] hrdata_out;
  logic        hreadyout_out;
  logic        hresp_out;
  logic        irq_out;

  // ------------------------------------------------------------
  // Bench state
  // ------------------------------------------------------------
  int          bad_count = 0;   // Mismatches seen
  int          cmp_count = 0;   // Comparisons made
  logic [3:0]  fl;              // Expected dword flags
  logic [3:0]  ist;             // Expected interrupt status
  logic [3:0]  msk;             // Expected interrupt mask

  assign hready_in = hreadyout_out;

  pss_regs #(.ADDR_W(8)) i_pss_regs
  (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .fwd_mode_in   (fwd_mode_in),
    .sec_freq_in   (sec_freq_in),
    .events_in     (events_in),
    .hsel_in       (hsel_in),
    .haddr_in      (haddr_in),
    .htrans_in     (htrans_in),
    .hwrite_in     (hwrite_in),
    .hsize_in      (hsize_in),
    .hwdata_in     (hwdata_in),
    .hready_in     (hready_in),
    .hrdata_out    (hrdata_out),
    .hreadyout_out (hreadyout_out),
    .hresp_out     (hresp_out),
    .irq_out       (irq_out)
  );

  // 200 MHz core clock
  always #2.5 clk_in = ~clk_in;

  // ------------------------------------------------------------
  // Checking helpers
  // ------------------------------------------------------------
  // Capability dword as the mode and inputs dictate
  function automatic logic [31:0] exp_cap(input logic fwd,
                                          input logic [2:0] fr,
                                          input logic [3:0] f);
    exp_cap = {7'h00, (fwd ? fr : 3'h0), f, fwd, 1'b0,
               PSS_NEXT_CAP, 8'h00};
  endfunction : exp_cap

  task automatic check32(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : check32

  task automatic check1(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask : check1

  task automatic print_verdict();
    if (bad_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict

  // ------------------------------------------------------------
  // Bus master: one single word transfer, entered just after an edge
  // ------------------------------------------------------------
  // Waits are bounded only so a dead slave cannot stall the loop
  task automatic bus_xfer(input logic wr, input logic [7:0] a,
                          input logic [31:0] wd,
                          output logic [31:0] rd);
    int n;
    hsel_in   <= 1'b1;
    haddr_in  <= {24'h000000, a};
    htrans_in <= PSS_HTRANS_NONSEQ;
    hwrite_in <= wr;
    hsize_in  <= PSS_HSIZE_WORD;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (hreadyout_out !== 1'b1 && n < 64);
    // A timed-out wait shows up here as a mismatch
    check1("hready_addr", 1'b1, hreadyout_out);
    htrans_in <= 2'h0;
    hwdata_in <= wd;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (hreadyout_out !== 1'b1 && n < 64);
    check1("hready_data", 1'b1, hreadyout_out);
    rd = hrdata_out;
    check1("hresp", PSS_HRESP_OKAY, hresp_out);
  endtask : bus_xfer

  // ------------------------------------------------------------
  // One pass in a given bridge mode
  // ------------------------------------------------------------
  task automatic run_mode(input logic fwd);
    logic [31:0] rd;
    logic [31:0] w;
    logic [3:0]  ev;
    logic [3:0]  en;
    // Flags that exist in this mode
    en = fwd ? 4'hD : 4'hE;
    fl = 4'h0;
    ist = 4'h0;
    rst_n_in    <= 1'b0;
    fwd_mode_in <= fwd;
    sec_freq_in <= 3'h2;
    repeat (8) @(posedge clk_in);
    rst_n_in    <= 1'b1;
    // Strap flips after release; the caught mode must hold
    fwd_mode_in <= ~fwd;
    @(posedge clk_in);
    check1("irq_rst", 1'b0, irq_out);
    bus_xfer(1'b0, PSS_OFF_CAP, 32'h0, rd);
    check32("cap_rst", exp_cap(fwd, 3'h2, 4'h0), rd);
    bus_xfer(1'b0, PSS_OFF_IMASK, 32'h0, rd);
    check32("mask_rst", {28'h0, PSS_MASK_RST}, rd);
    // Every frequency code, reserved ones too
    for (int f = 0; f < 8; f++)
    begin
      sec_freq_in <= f[2:0];
      @(posedge clk_in);
      bus_xfer(1'b0, PSS_OFF_CAP, 32'h0, rd);
      check32("cap_freq", exp_cap(fwd, f[2:0], 4'h0), rd);
    end
    // Unmapped place: write ignored, reads zero
    bus_xfer(1'b1, 8'h84, 32'hFFFF_FFFF, rd);
    bus_xfer(1'b0, 8'h84, 32'h0, rd);
    check32("unmapped", 32'h0, rd);
    msk = 4'hF;
    bus_xfer(1'b1, PSS_OFF_IMASK, {28'h0, msk}, rd);
    // Random events, clears and mask changes
    for (int i = 0; i < 24; i++)
    begin
      ev = 4'($urandom);
      events_in <= pss_evt_t'(ev);
      @(posedge clk_in);
      events_in <= pss_evt_t'(4'h0);
      fl  = fl | (ev & en);
      ist = ist | (ev & en);
      if (ev[0] || i == 23)
      begin
        // Random word also hits read-only and reserved bits
        w = (i == 23) ? 32'hFFFF_FFFF : $urandom;
        bus_xfer(1'b1, PSS_OFF_CAP, w, rd);
        fl = fl & ~w[21:18];
        bus_xfer(1'b1, PSS_OFF_ISTAT, w, rd);
        ist = ist & ~w[3:0];
      end
      if (ev[1])
      begin
        msk = 4'($urandom);
        bus_xfer(1'b1, PSS_OFF_IMASK, {28'h0, msk}, rd);
        bus_xfer(1'b0, PSS_OFF_IMASK, 32'h0, rd);
        check32("mask", {28'h0, msk}, rd);
      end
      bus_xfer(1'b0, PSS_OFF_CAP, 32'h0, rd);
      check32("cap", exp_cap(fwd, 3'h7, fl), rd);
      // Writing zeros must leave every flag as it was
      bus_xfer(1'b1, PSS_OFF_CAP, 32'h0000_0000, rd);
      bus_xfer(1'b0, PSS_OFF_CAP, 32'h0, rd);
      check32("cap_again", exp_cap(fwd, 3'h7, fl), rd);
      bus_xfer(1'b0, PSS_OFF_ISTAT, 32'h0, rd);
      check32("irq_status", {28'h0, ist}, rd);
      check1("irq_out", |(ist & msk), irq_out);
    end
  endtask : run_mode

  // ------------------------------------------------------------
  // Main sequence: forward first, then reverse after a fresh reset
  // ------------------------------------------------------------
  initial
  begin
    void'($urandom(66));
    events_in   = pss_evt_t'(4'h0);
    hsel_in     = 1'b0;
    haddr_in    = 32'h0000_0000;
    htrans_in   = 2'h0;
    hwrite_in   = 1'b0;
    hsize_in    = 3'h0;
    hwdata_in   = 32'h0000_0000;
    run_mode(1'b1);
    run_mode(1'b0);
    print_verdict();
  end

  // Watchdog: the run needs a few thousand cycles at most
  initial
  begin
    repeat (20000) @(posedge clk_in);
    bad_count++;
    print_verdict();
  end

endmodule : pss_regs_bench
